// [design/skew_fanout_pkg.sv]
// package: map, fields, reset values and timing counts of the fanout control
package skew_fanout_pkg;
    localparam logic [3:0] CTRL_OFS = 4'h0;
    localparam logic [3:0] SKEW_OFS = 4'h4;
    localparam logic [3:0] STAT_OFS = 4'h8;
    localparam int NPAIR = 4;
    localparam int ALWAYS_ON_PAIR = 2;
    localparam int INVERT_PAIR = 3;
    // three-level pin encoding; 2'h3 stands for an undriven pin
    localparam logic [1:0] LVL_LOW = 2'h0;
    localparam logic [1:0] LVL_MID = 2'h1;
    localparam logic [1:0] LVL_HIGH = 2'h2;
    localparam logic [1:0] LVL_OPEN = 2'h3;
    // time unit in aclk cycles for each oscillator range
    localparam int TU_LOW = 1;
    localparam int TU_MID = 2;
    localparam int TU_HIGH = 3;
    localparam int SKEW_SPAN = 6;
    localparam int HIST_DEPTH = 2 * SKEW_SPAN * TU_HIGH + 2;
    localparam logic [3:0] CODE_LL = 4'h0;
    localparam logic [3:0] CODE_HH = 4'h8;
    localparam logic [3:0] CODE_MM = 4'h4;
    localparam logic [31:0] SKEW_RESET = 32'h0000ffff;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic [1:0] range_sel;
        logic [1:0] test_lvl;
        logic polarity;
        logic oe_n;
    } ctrl_s;

    localparam ctrl_s CTRL_RESET = '{range_sel: LVL_OPEN, test_lvl: LVL_LOW,
                                     polarity: 1'b1, oe_n: 1'b0};
    localparam int CTRL_W = $bits(ctrl_s);

    typedef struct packed {
        logic [1:0] f1;
        logic [1:0] f0;
    } pair_sel_s;
endpackage

// [design/skew_clock_fanout_control.sv]
// skew clock fanout control with its AXI4-Lite register slave
//
// Local design decisions: register access over AXI4-Lite and the register addresses.
`timescale 1ns/10ps

// Summary of operation
// R1: output enable low runs all outputs synchronously
// R2: enable high stops outputs low, pair three excepted
// R3: pair three keeps toggling for loop feedback
// R4: polarity high aligns outputs to rising reference
// R5: polarity low aligns outputs to falling reference
// R6: test mid or high bypasses loop to reference
// R7: skew stays applied in bypass; test low normal
// R8: test mid, enable high: LL pairs disabled
// R9: non-LL pairs keep skew in that mode
// R10: two three-level selects decode nine settings
// R11: range select picks oscillator range
// R12: eight outputs, four pairs sharing one setting
// R13: skew can lead or lag the reference
// R14: far side drives selects to three levels
// R15: undriven three-level input reads as middle
// R16: skew is integer multiple of time unit
// R17: inverted pair four stops at polarity level
// R18: stop and restart only at period boundary
module skew_clock_fanout_control
    import skew_fanout_pkg::*;
(
    input wire logic aclk, // 250 MHz system clock
    input wire logic aresetn, // synchronous reset, active low
    input wire logic ref_clk_in, // reference clock, sampled
    input wire logic loop_return_in, // loop feedback, sampled
    output logic [NPAIR-1:0][1:0] pair_clock_out, // four output pairs
    input wire logic [3:0] s_axi_awaddr, // write address
    input wire logic s_axi_awvalid, // write address valid
    output logic s_axi_awready, // write address ready
    input wire logic [31:0] s_axi_wdata, // write data
    input wire logic [3:0] s_axi_wstrb, // write byte strobes
    input wire logic s_axi_wvalid, // write data valid
    output logic s_axi_wready, // write data ready
    output logic [1:0] s_axi_bresp, // write response
    output logic s_axi_bvalid, // write response valid
    input wire logic s_axi_bready, // write response ready
    input wire logic [3:0] s_axi_araddr, // read address
    input wire logic s_axi_arvalid, // read address valid
    output logic s_axi_arready, // read address ready
    output logic [31:0] s_axi_rdata, // read data
    output logic [1:0] s_axi_rresp, // read response
    output logic s_axi_rvalid, // read data valid
    input wire logic s_axi_rready // read data ready
);

    function automatic logic [1:0] level_norm(input logic [1:0] l);
        return (l == LVL_OPEN) ? LVL_MID : l; // R15
    endfunction

    // setting code is 3*f1 + f0, so MM lands on 4
    function automatic logic [3:0] sel_code(input pair_sel_s s);
        logic [3:0] a;
        logic [3:0] b;
        a = {2'h0, level_norm(s.f1)};
        b = {2'h0, level_norm(s.f0)};
        return 4'((a << 1) + a + b); // R10
    endfunction

    // ---------------- register bus ----------------
    ctrl_s ctrl_q, ctrl_d;
    logic [31:0] skew_q, skew_d;
    logic aw_full_q, aw_full_d, w_full_q, w_full_d;
    logic [3:0] awaddr_q, awaddr_d;
    logic [31:0] wdata_q, wdata_d;
    logic [3:0] wstrb_q, wstrb_d;
    logic bvalid_q, bvalid_d;
    logic [1:0] bresp_q, bresp_d;
    logic rvalid_q, rvalid_d;
    logic [1:0] rresp_q, rresp_d;
    logic [31:0] rdata_q, rdata_d;
    logic [31:0] status;
    logic [31:0] wmask;
    logic [31:0] ctrl_word;

    // one write in flight: both halves wait while the answer is pending
    assign s_axi_awready = !aw_full_q && !bvalid_q;
    assign s_axi_wready = !w_full_q && !bvalid_q;
    // single read buffer, so no new address until rdata is taken
    assign s_axi_arready = !rvalid_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rresp = rresp_q;
    assign s_axi_rdata = rdata_q;

    // write halves are held until both are in, then committed together
    always_comb begin
        ctrl_d = ctrl_q;
        skew_d = skew_q;
        aw_full_d = aw_full_q;
        w_full_d = w_full_q;
        awaddr_d = awaddr_q;
        wdata_d = wdata_q;
        wstrb_d = wstrb_q;
        bvalid_d = bvalid_q;
        bresp_d = bresp_q;
        rvalid_d = rvalid_q;
        rresp_d = rresp_q;
        rdata_d = rdata_q;
        wmask = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}},
                 {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
        // control bits above the struct width do not exist
        ctrl_word = (32'(ctrl_q) & ~wmask) | (wdata_q & wmask);
        if (s_axi_awvalid && s_axi_awready) begin
            aw_full_d = 1'b1;
            awaddr_d = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            w_full_d = 1'b1;
            wdata_d = s_axi_wdata;
            wstrb_d = s_axi_wstrb;
        end
        // both halves held: commit and answer next cycle
        if (aw_full_q && w_full_q) begin
            aw_full_d = 1'b0;
            w_full_d = 1'b0;
            bvalid_d = 1'b1;
            bresp_d = RESP_OKAY;
            case ({awaddr_q[3:2], 2'h0})
                CTRL_OFS: begin
                    ctrl_d = ctrl_s'(ctrl_word[CTRL_W-1:0]);
                end
                SKEW_OFS: begin
                    skew_d = ((skew_q & ~wmask) | (wdata_q & wmask))
                             & 32'h0000ffff;
                end
                // status is read-only: the write is dropped, answered OKAY
                STAT_OFS: bresp_d = RESP_OKAY;
                default: bresp_d = RESP_SLVERR;
            endcase
        end
        if (bvalid_q && s_axi_bready) begin
            bvalid_d = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            rvalid_d = 1'b1;
            rresp_d = RESP_OKAY;
            case ({s_axi_araddr[3:2], 2'h0})
                CTRL_OFS: rdata_d = 32'(ctrl_q);
                SKEW_OFS: rdata_d = skew_q;
                STAT_OFS: rdata_d = status;
                default: begin
                    rdata_d = 32'h0;
                    rresp_d = RESP_SLVERR;
                end
            endcase
        end else if (rvalid_q && s_axi_rready) begin
            rvalid_d = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_q <= CTRL_RESET;
            skew_q <= SKEW_RESET; // R15
            aw_full_q <= 1'b0;
            w_full_q <= 1'b0;
            awaddr_q <= 4'h0;
            wdata_q <= 32'h0;
            wstrb_q <= 4'h0;
            bvalid_q <= 1'b0;
            bresp_q <= RESP_OKAY;
            rvalid_q <= 1'b0;
            rresp_q <= RESP_OKAY;
            rdata_q <= 32'h0;
        end else begin
            ctrl_q <= ctrl_d;
            skew_q <= skew_d;
            aw_full_q <= aw_full_d;
            w_full_q <= w_full_d;
            awaddr_q <= awaddr_d;
            wdata_q <= wdata_d;
            wstrb_q <= wstrb_d;
            bvalid_q <= bvalid_d;
            bresp_q <= bresp_d;
            rvalid_q <= rvalid_d;
            rresp_q <= rresp_d;
            rdata_q <= rdata_d;
        end
    end

    // ---------------- clock path ----------------
    logic [1:0] test_n, range_n;
    logic bypass, test_mid_dis, loop_active;
    int tu;
    int zero_idx;
    logic [HIST_DEPTH-1:0] hist_q, hist_d;
    logic zero_tap, zero_rise;
    logic div2_q, div2_d;
    logic [1:0] div4_q, div4_d;
    logic ret_prev_q, ret_prev_d;
    logic lock_q, lock_d;
    logic [NPAIR-1:0] raw, stop_lvl, en, gate_q, gate_d;
    logic [NPAIR-1:0][1:0] out_d;

    // undriven test or range pins count as middle level
    assign test_n = level_norm(ctrl_q.test_lvl);
    assign range_n = level_norm(ctrl_q.range_sel);
    assign bypass = (test_n != LVL_LOW); // R6 R7
    assign test_mid_dis = (test_n == LVL_MID) && ctrl_q.oe_n; // R8
    assign loop_active = !bypass || test_mid_dis; // R8
    // R11 R16
    assign tu = (range_n == LVL_LOW) ? TU_LOW :
                (range_n == LVL_HIGH) ? TU_HIGH : TU_MID;
    // zero skew sits mid-line so that lead taps exist ahead of it
    assign zero_idx = SKEW_SPAN * tu; // R13
    assign zero_tap = hist_q[zero_idx];
    // zero-tap rise paces the divide-by-two and divide-by-four modes
    assign zero_rise = zero_tap && !hist_q[zero_idx + 1];

    always_comb begin
        // R4 R5: falling edge alignment is the inverted reference
        hist_d = {hist_q[HIST_DEPTH-2:0],
                  ctrl_q.polarity ? ref_clk_in : !ref_clk_in};
        // dividers follow the zero tap, so polarity and range apply too
        div2_d = zero_rise ? !div2_q : div2_q;
        div4_d = zero_rise ? 2'(div4_q + 2'h1) : div4_q;
        ret_prev_d = loop_return_in;
        // lock is only reported: no output waits for it
        lock_d = lock_q;
        if (!loop_active) begin
            lock_d = 1'b0;
        end else if (loop_return_in && !ret_prev_q) begin
            lock_d = zero_tap;
        end
    end

    // per-pair tap select, enable and glitch-free gate
    genvar p;
    for (p = 0; p < NPAIR; p++) begin : g_pair
        pair_sel_s sel;
        logic [3:0] code;
        assign sel = pair_sel_s'(skew_q[4*p +: 4]);
        assign code = sel_code(sel);
        always_comb begin
            int step;
            int idx;
            step = 0;
            idx = 0;
            stop_lvl[p] = 1'b0;
            if (p < ALWAYS_ON_PAIR) begin
                step = 1;
            end else begin
                step = 2;
            end
            // LL on the wide pairs would index before the line, HH past its end in the high range
            if (p >= ALWAYS_ON_PAIR && code == CODE_LL) begin
                raw[p] = div2_q;
            end else if (p >= ALWAYS_ON_PAIR && code == CODE_HH) begin
                if (p == INVERT_PAIR) begin
                    raw[p] = !zero_tap;
                    stop_lvl[p] = ctrl_q.polarity; // R17
                end else begin
                    raw[p] = div4_q[1];
                end
            end else begin
                // R10 R12 R13 R16
                idx = zero_idx + (int'(code) - int'(CODE_MM)) * step * tu;
                raw[p] = hist_q[idx];
            end
            // test mid with enable high turns LL into a per-pair disable
            if (test_mid_dis) begin
                en[p] = (code != CODE_LL); // R8 R9
            end else begin
                en[p] = !ctrl_q.oe_n || (p == ALWAYS_ON_PAIR); // R1 R2 R3
            end
            // gate moves only while the pair sits at its stop level
            gate_d[p] = (raw[p] == stop_lvl[p]) ? en[p] : gate_q[p]; // R18
            out_d[p] = gate_q[p] ? {2{raw[p]}} : {2{stop_lvl[p]}}; // R2 R12
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            hist_q <= '0;
            div2_q <= 1'b0;
            div4_q <= 2'h0;
            ret_prev_q <= 1'b0;
            lock_q <= 1'b0;
            gate_q <= '0;
            pair_clock_out <= '0;
        end else begin
            hist_q <= hist_d;
            div2_q <= div2_d;
            div4_q <= div4_d;
            ret_prev_q <= ret_prev_d;
            lock_q <= lock_d;
            gate_q <= gate_d;
            pair_clock_out <= out_d;
        end
    end

    // status bits: gates, lock, loop active, bypass
    assign status = {24'h0, 1'b0, bypass, loop_active, lock_q, gate_q};

endmodule // skew_clock_fanout_control

// [verif/skew_ref_source.sv]
// reference clock source and feedback return
`timescale 1ns/10ps
module skew_ref_source #(
    parameter int HALF = 5
) (
    input wire logic aclk, // system clock
    input wire logic [1:0] fb_pair, // always-on pair
    output logic ref_clk_in, // free running reference
    output logic loop_return_in // feedback return
);
    int cnt = 0;
    logic ref_q = 1'b0;
    logic ret_q = 1'b0;
    assign ref_clk_in = ref_q;
    assign loop_return_in = ret_q;
    // feedback from the always-on pair, so a stop keeps lock
    always @(posedge aclk) begin
        cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
        if (cnt == HALF - 1) ref_q <= ~ref_q;
        ret_q <= fb_pair[0];
    end
endmodule // skew_ref_source

// [verif/skew_fanout_props.sv]
// port checker for the skew clock fanout control
`timescale 1ns/10ps
module skew_fanout_props
    import skew_fanout_pkg::*;
(
    input wire logic aclk, // clock
    input wire logic aresetn, // reset
    input wire logic [NPAIR-1:0][1:0] pair_clock_out, // pairs
    input wire logic [3:0] s_axi_awaddr, // aw addr
    input wire logic s_axi_awvalid, // aw valid
    input wire logic s_axi_awready, // aw ready
    input wire logic [31:0] s_axi_wdata, // w data
    input wire logic s_axi_wvalid, // w valid
    input wire logic s_axi_wready, // w ready
    input wire logic s_axi_bvalid, // b valid
    input wire logic [3:0] s_axi_araddr, // ar addr
    input wire logic s_axi_arvalid, // ar valid
    input wire logic s_axi_arready, // ar ready
    input wire logic [31:0] s_axi_rdata, // r data
    input wire logic [1:0] s_axi_rresp, // r resp
    input wire logic s_axi_rvalid // r valid
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    ctrl_s ctrl_q, ctrl_d;
    logic [5:0] stop_q, stop_d;
    logic wr_take, pairs_ok;
    assign wr_take = s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready;
    assign pairs_ok = ~|{^pair_clock_out[0], ^pair_clock_out[1],
        ^pair_clock_out[2], ^pair_clock_out[3]};
    // shadow control word; assumes both write halves taken together
    always_comb begin
        ctrl_d = ctrl_q;
        stop_d = (stop_q == 6'h3f) ? stop_q : stop_q + 6'h01;
        if (wr_take && s_axi_awaddr == CTRL_OFS) ctrl_d = s_axi_wdata[5:0];
        if (!ctrl_q.oe_n || ctrl_q.test_lvl != LVL_LOW || wr_take) stop_d = '0;
        if (!aresetn) begin
            ctrl_d = CTRL_RESET;
            stop_d = '0;
        end
    end
    always_ff @(posedge aclk) begin
        ctrl_q <= ctrl_d;
        stop_q <= stop_d;
    end
    sequence wr_take_s;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence rd_take_s;
        s_axi_arvalid && s_axi_arready;
    endsequence
    AST_PAIR_SAME: assert property (pairs_ok)
        else $error("pair bits differ");
    AST_STOP_LOW: assert property (stop_q == 6'h3f |->
        pair_clock_out[0] == 2'h0 && pair_clock_out[1] == 2'h0)
        else $error("stopped pair not low");
    AST_FB_RUNS: assert property (stop_q == 6'h3f |->
        ##[1:24] pair_clock_out[2] != $past(pair_clock_out[2]))
        else $error("feedback pair not toggling");
    AST_WR_RESP: assert property (wr_take_s |=>
        !s_axi_bvalid ##[1:2] s_axi_bvalid) else $error("write answer late");
    AST_RD_RESP: assert property (rd_take_s |=> s_axi_rvalid)
        else $error("read answer late");
    AST_B_BLOCK: assert property (s_axi_bvalid |-> !s_axi_awready
        && !s_axi_wready) else $error("write taken while answering");
    AST_R_BLOCK: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while answering");
    AST_UNMAPPED: assert property (rd_take_s ##0 s_axi_araddr[3:2] == 2'h3
        |=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0)
        else $error("unmapped read not refused");
    AST_RESET_QUIET: assert property (@(posedge aclk) disable iff (1'b0)
        !aresetn |=> pair_clock_out == '0 && !s_axi_bvalid && !s_axi_rvalid)
        else $error("outputs active in reset");
endmodule // skew_fanout_props
bind skew_clock_fanout_control skew_fanout_props skew_fanout_props_i (
    .aclk, .aresetn, .pair_clock_out, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bvalid, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid);

// [verif/skew_clock_fanout_control_tb.sv]
// self-checking bench for the skew clock fanout control
`timescale 1ns/10ps
module skew_clock_fanout_control_tb;
    import skew_fanout_pkg::*;
    logic aclk = 1'b0, aresetn = 1'b0, ref_clk_in, loop_return_in;
    logic [NPAIR-1:0][1:0] pair_clock_out;
    logic [3:0] s_axi_awaddr = '0, s_axi_araddr = '0, s_axi_wstrb = 4'hf;
    logic [31:0] s_axi_wdata = '0, s_axi_rdata;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready;
    logic s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [63:0] hist = '0;
    int miscompares = 0, samples_checked = 0;
    int tus[3] = '{TU_LOW, TU_MID, TU_HIGH};
    int sk[4] = '{1, -1, -4, 6};
    always #2 aclk = ~aclk;
    always @(posedge aclk) hist <= {hist[62:0], ref_clk_in};
    skew_clock_fanout_control skew_clock_fanout_control_i (.aclk, .aresetn,
        .ref_clk_in, .loop_return_in, .pair_clock_out, .s_axi_awaddr,
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
    skew_ref_source skew_ref_source_i (.aclk, .ref_clk_in, .loop_return_in,
        .fb_pair(pair_clock_out[ALWAYS_ON_PAIR]));
    task check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
        check(32'(s_axi_bresp), 32'(RESP_OKAY));
    endtask
    task rd(input logic [3:0] a, input logic [31:0] exp, input logic [1:0] e);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
        check(s_axi_rdata, exp);
        check(32'(s_axi_rresp), 32'(e));
    endtask
    // d: lag behind ref_clk_in in aclk cycles; hist[k] lags it by k + 1
    // d below zero: pair must sit at level inv
    task outs(input int p, input int d, input logic inv);
        repeat (80) @(posedge aclk);
        repeat (20) begin
            @(negedge aclk);
            check(32'(pair_clock_out[p]),
                  32'(d < 0 ? {2{inv}} : {2{hist[d - 1] ^ inv}}));
        end
    endtask
    task wrap_up;
        $display("%0d mismatches in %0d checks", miscompares, samples_checked);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // whole sequence needs about 1700 cycles
    initial begin
        repeat (6000) @(posedge aclk);
        miscompares++;
        wrap_up;
    end
    initial begin
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        rd(CTRL_OFS, 32'(CTRL_RESET), RESP_OKAY);
        rd(SKEW_OFS, SKEW_RESET, RESP_OKAY);
        rd(4'hc, 32'h0, RESP_SLVERR);
        wr(STAT_OFS, 32'hffffffff);
        outs(1, 2 + 6 * TU_MID, 1'b0);
        for (int r = 0; r < 3; r++) begin
            wr(CTRL_OFS, {26'h0, 2'(r), LVL_LOW, 2'b10});
            outs(3, 2 + 6 * tus[r], 1'b0);
        end
        wr(SKEW_OFS, 32'h00009246);
        rd(SKEW_OFS, 32'h00009246, RESP_OKAY);
        for (int p = 0; p < 4; p++) begin
            outs(p, 2 + (6 + sk[p]) * TU_HIGH, 1'b0);
        end
        wr(CTRL_OFS, {26'h0, LVL_HIGH, LVL_LOW, 2'b00});
        outs(0, 2 + 7 * TU_HIGH, 1'b1);
        wr(SKEW_OFS, 32'h0000a246);
        wr(CTRL_OFS, {26'h0, LVL_HIGH, LVL_LOW, 2'b11});
        outs(0, -1, 1'b0);
        outs(2, 2 + 2 * TU_HIGH, 1'b0);
        outs(3, -1, 1'b1);
        wr(CTRL_OFS, {26'h0, LVL_HIGH, LVL_LOW, 2'b10});
        outs(0, 2 + 7 * TU_HIGH, 1'b0);
        wr(SKEW_OFS, 32'h0000a240);
        wr(CTRL_OFS, {26'h0, LVL_HIGH, LVL_MID, 2'b11});
        outs(0, -1, 1'b0);
        outs(1, 2 + 5 * TU_HIGH, 1'b0);
        wr(CTRL_OFS, {26'h0, LVL_HIGH, LVL_HIGH, 2'b10});
        outs(1, 2 + 5 * TU_HIGH, 1'b0);
        rd(STAT_OFS, 32'h0000004f, RESP_OKAY);
        wrap_up;
    end
endmodule // skew_clock_fanout_control_tb
